//--- hw/pec_pkg.sv
// constants and types of the pin edge change interrupt block
// assumes a 32-bit avalon-mm slave port with byte addresses
package pec_pkg;

	localparam int unsigned PINS   = 8;
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 32;

	localparam logic [4:0] OFF_RISE_EN  = 5'h00;
	localparam logic [4:0] OFF_FALL_EN  = 5'h04;
	localparam logic [4:0] OFF_FLAGS    = 5'h08;
	localparam logic [4:0] OFF_CTRL     = 5'h0c;
	localparam logic [4:0] OFF_IRQ_STAT = 5'h10;
	localparam logic [4:0] OFF_IRQ_MASK = 5'h14;

	localparam int unsigned CTRL_MEN_BIT = 0;
	localparam int unsigned CTRL_SUM_BIT = 1;
	localparam int unsigned STAT_CHG_BIT  = 0;
	localparam int unsigned STAT_WAKE_BIT = 1;

	localparam logic [7:0] RST_RISE_EN  = 8'h00;
	localparam logic [7:0] RST_FALL_EN  = 8'h00;
	localparam logic [7:0] RST_FLAGS    = 8'h00;
	localparam logic       RST_MEN      = 1'h0;
	localparam logic [1:0] RST_IRQ_STAT = 2'h0;
	localparam logic [1:0] RST_IRQ_MASK = 2'h0;
	localparam logic [31:0] RD_ZERO     = 32'h0000_0000;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} pec_bus_state_t;

endpackage

//--- hw/pec_edge_if.sv
// enables toward and edge events from the per-pin detector
// assumes both ends sit in the clk_i domain
`timescale 1ns/100ps
`default_nettype none
interface pec_edge_if;
	logic [7:0] rise_en;
	logic [7:0] fall_en;
	logic [7:0] rise_ev;
	logic [7:0] fall_ev;

	modport ctrl (
		output rise_en,
		output fall_en,
		input  rise_ev,
		input  fall_ev
	);

	modport det (
		input  rise_en,
		input  fall_en,
		output rise_ev,
		output fall_ev
	);
endinterface
`default_nettype wire

//--- hw/pec_edge_detect.sv
// per-pin synchroniser and rising / falling edge detectors
// assumes pins are asynchronous to clk_i; events are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
module pec_edge_detect (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [7:0] pins_i,
	pec_edge_if.det         edge_if
);

	logic [7:0] meta_q;
	logic [7:0] sync_q;
	logic [7:0] prev_q;

	genvar g;
	generate
		for (g = 0; g < pec_pkg::PINS; g++) begin : g_pin
			// meta_q feeds sync_q only
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					meta_q[g] <= 1'b0;
					sync_q[g] <= 1'b0;
					prev_q[g] <= 1'b0;
				end else begin
					meta_q[g] <= pins_i[g]; // RULE_14
					sync_q[g] <= meta_q[g];
					prev_q[g] <= sync_q[g];
				end
			end
			// both detectors are independent, so either may fire per pin
			assign edge_if.rise_ev[g] = sync_q[g] & ~prev_q[g] & edge_if.rise_en[g]; // RULE_01
			assign edge_if.fall_ev[g] = ~sync_q[g] & prev_q[g] & edge_if.fall_en[g]; // RULE_02
		end
	endgenerate

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_rise_gated: assert property ( // RULE_01
		edge_if.rise_ev == ($past(pins_i, 2) & ~$past(pins_i, 3) & edge_if.rise_en))
		else $error("rising event disagrees with pin history");
	a_fall_gated: assert property ( // RULE_02
		edge_if.fall_ev == (~$past(pins_i, 2) & $past(pins_i, 3) & edge_if.fall_en))
		else $error("falling event disagrees with pin history");
	a_both_dirs: assert property ((edge_if.rise_en[0] && edge_if.fall_en[0] // RULE_03
		&& ($past(pins_i[0], 2) != $past(pins_i[0], 3)))
		|-> (edge_if.rise_ev[0] || edge_if.fall_ev[0]))
		else $error("pin with both enables missed an edge");

endmodule
`default_nettype wire

//--- hw/pec_top.sv
// pin edge change interrupt: registers, flags, interrupt and wake logic
// assumes an avalon-mm master on clk_i and pins from outside the chip
`timescale 1ns/100ps
`default_nettype none

// What this block does
// [RULE_01] Each pin has its own rising detector, live only while its rise enable bit is one.
// [RULE_02] Each pin's falling detector is live only while its fall enable bit is one.
// [RULE_03] With both enable bits set a pin catches edges of either direction.
// [RULE_04] An enabled edge sets the pin's sticky flag; an interrupt is asked only under the master enable. change_irq_o and wake_o are gated; irq_o is not.
// [RULE_05] The summary flag is the OR of the eight pin flags with no storage of its own.
// [RULE_06] Software clears flags by writing zeros, but an edge in the same cycle leaves its flag set.
// [RULE_07] Software should clear flags by AND-ing out only the bits it has already seen.
// [RULE_08] An enabled edge during sleep asks for wake-up when the master enable is one.
// [RULE_09] An edge caught in sleep is in the flag register before the core runs again.
// [RULE_10] The rise enable register is eight read/write bits, one per pin, reset to zero.
// [RULE_11] The fall enable register is eight read/write bits, one per pin, reset to zero.
// [RULE_12] The flag register is eight read/write bits set by hardware, reset to zero.
// [RULE_13] Detection and flag setting go on with the master enable off; only the request stops.
// [RULE_14] Each pin is synchronised and an edge is found by comparing successive samples.
module pec_top (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [4:0]  avm_address_i,
	input  wire logic        avm_read_i,
	input  wire logic        avm_write_i,
	input  wire logic [31:0] avm_writedata_i,
	input  wire logic [3:0]  avm_byteenable_i,
	output logic      [31:0] avm_readdata_o,
	output logic             avm_waitrequest_o,
	input  wire logic [7:0]  watched_pin_i,
	input  wire logic        sleep_i,
	output logic             change_irq_o,
	output logic             wake_o,
	output logic             irq_o
);

	pec_edge_if edge_if ();

	pec_pkg::pec_bus_state_t state_q;
	logic [31:0]             rdata_q;
	logic                    wait_q;
	logic [7:0]              rise_en_q;
	logic [7:0]              fall_en_q;
	logic [7:0]              flags_q;
	logic [7:0]              flags_d;
	logic                    men_q;
	logic [1:0]              stat_q;
	logic [1:0]              stat_d;
	logic [1:0]              mask_q;
	logic                    chg_irq_q;
	logic                    wake_q;
	logic                    irq_q;
	logic [7:0]              edge_ev;
	logic                    summary;
	logic                    req;
	logic                    ack;
	logic                    wr_lane0;
	logic [31:0]             rd_mux;

	pec_edge_detect u_detect (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.pins_i  (watched_pin_i),
		.edge_if (edge_if)
	);

	assign edge_if.rise_en = rise_en_q;
	assign edge_if.fall_en = fall_en_q;
	assign edge_ev         = edge_if.rise_ev | edge_if.fall_ev; // RULE_03

	// summary is pure logic over the flags so it can never disagree with them
	assign summary = |flags_q; // RULE_05

	// bus handshake: one wait cycle, answer in the second
	assign req      = avm_read_i | avm_write_i;
	assign ack      = (state_q == pec_pkg::BUS_ACK);
	assign wr_lane0 = avm_write_i & ack & avm_byteenable_i[0];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= pec_pkg::BUS_IDLE;
		end else begin
			unique case (state_q)
				pec_pkg::BUS_IDLE: begin
					if (req) begin
						state_q <= pec_pkg::BUS_ACK;
					end
				end
				pec_pkg::BUS_ACK: begin
					state_q <= pec_pkg::BUS_IDLE;
				end
				default: begin
					state_q <= pec_pkg::BUS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= !((state_q == pec_pkg::BUS_IDLE) && req);
		end
	end

	always_comb begin
		rd_mux = pec_pkg::RD_ZERO;
		unique case (avm_address_i)
			pec_pkg::OFF_RISE_EN: begin
				rd_mux[7:0] = rise_en_q;
			end
			pec_pkg::OFF_FALL_EN: begin
				rd_mux[7:0] = fall_en_q;
			end
			pec_pkg::OFF_FLAGS: begin
				rd_mux[7:0] = flags_q;
			end
			pec_pkg::OFF_CTRL: begin
				rd_mux[pec_pkg::CTRL_MEN_BIT] = men_q;
				rd_mux[pec_pkg::CTRL_SUM_BIT] = summary; // RULE_05
			end
			pec_pkg::OFF_IRQ_STAT: begin
				rd_mux[1:0] = stat_q;
			end
			pec_pkg::OFF_IRQ_MASK: begin
				rd_mux[1:0] = mask_q;
			end
			default: begin
				rd_mux = pec_pkg::RD_ZERO;
			end
		endcase
	end

	// read data is captured as the wait cycle ends and stands through the answer
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= pec_pkg::RD_ZERO;
		end else if ((state_q == pec_pkg::BUS_IDLE) && avm_read_i) begin
			rdata_q <= rd_mux;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rise_en_q <= pec_pkg::RST_RISE_EN;
		end else if (wr_lane0 && (avm_address_i == pec_pkg::OFF_RISE_EN)) begin
			rise_en_q <= avm_writedata_i[7:0]; // RULE_10
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fall_en_q <= pec_pkg::RST_FALL_EN;
		end else if (wr_lane0 && (avm_address_i == pec_pkg::OFF_FALL_EN)) begin
			fall_en_q <= avm_writedata_i[7:0]; // RULE_11
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			men_q <= pec_pkg::RST_MEN;
		end else if (wr_lane0 && (avm_address_i == pec_pkg::OFF_CTRL)) begin
			men_q <= avm_writedata_i[pec_pkg::CTRL_MEN_BIT];
		end
	end

	// a plain write can also set flags; software is expected to and-mask instead
	always_comb begin
		flags_d = flags_q;
		if (wr_lane0 && (avm_address_i == pec_pkg::OFF_FLAGS)) begin
			flags_d = avm_writedata_i[7:0]; // RULE_12 RULE_07
		end
		// set beats clear so an edge during the write is never lost
		flags_d = flags_d | edge_ev; // RULE_06 RULE_04 RULE_13
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flags_q <= pec_pkg::RST_FLAGS;
		end else begin
			flags_q <= flags_d; // RULE_12 RULE_09
		end
	end

	// request follows the same-cycle flags and enable, one flop late only
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			chg_irq_q <= 1'b0;
		end else begin
			chg_irq_q <= (|flags_d) & ((wr_lane0 && (avm_address_i == pec_pkg::OFF_CTRL))
				? avm_writedata_i[pec_pkg::CTRL_MEN_BIT] : men_q); // RULE_04
		end
	end

	// wake is a level while asleep; the flag is written on the same edge
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wake_q <= 1'b0;
		end else if (!sleep_i) begin
			wake_q <= 1'b0;
		end else if ((|edge_ev) && men_q) begin
			wake_q <= 1'b1; // RULE_08 RULE_09
		end
	end

	always_comb begin
		stat_d = stat_q;
		if (wr_lane0 && (avm_address_i == pec_pkg::OFF_IRQ_STAT)) begin
			stat_d = stat_q & ~avm_writedata_i[1:0];
		end
		stat_d[pec_pkg::STAT_CHG_BIT]  = stat_d[pec_pkg::STAT_CHG_BIT] | (|edge_ev);
		stat_d[pec_pkg::STAT_WAKE_BIT] = stat_d[pec_pkg::STAT_WAKE_BIT]
			| (sleep_i & (|edge_ev) & men_q);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stat_q <= pec_pkg::RST_IRQ_STAT;
		end else begin
			stat_q <= stat_d;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mask_q <= pec_pkg::RST_IRQ_MASK;
		end else if (wr_lane0 && (avm_address_i == pec_pkg::OFF_IRQ_MASK)) begin
			mask_q <= avm_writedata_i[1:0];
		end
	end

	// mask is compared with the current value, so irq_o trails a mask write by one
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(stat_d & mask_q);
		end
	end

	assign avm_readdata_o    = rdata_q;
	assign avm_waitrequest_o = wait_q;
	assign change_irq_o      = chg_irq_q;
	assign wake_o            = wake_q;
	assign irq_o             = irq_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_flag_write_with_edge;
		wr_lane0 && (avm_address_i == pec_pkg::OFF_FLAGS) && (|edge_ev);
	endsequence

	sequence s_rise_reg_write;
		wr_lane0 && (avm_address_i == pec_pkg::OFF_RISE_EN);
	endsequence

	a_flag_sets_edge: assert property ((|edge_ev) // RULE_04
		|=> ((flags_q & $past(edge_ev)) == $past(edge_ev)))
		else $error("edge did not set its flag");
	a_clear_keeps_edge: assert property (s_flag_write_with_edge // RULE_06
		|=> ((flags_q & $past(edge_ev)) == $past(edge_ev)))
		else $error("flag lost to a clearing write");
	a_change_irq_gate: assert property (change_irq_o == (summary && men_q)) // RULE_04
		else $error("change request does not follow flags and enable");
	a_ctrl_summary: assert property ((avm_read_i && (state_q == pec_pkg::BUS_IDLE) // RULE_05
		&& (avm_address_i == pec_pkg::OFF_CTRL))
		|=> (avm_readdata_o[pec_pkg::CTRL_SUM_BIT] == $past(summary)))
		else $error("summary bit read back wrong");
	a_master_off_flags: assert property ((!men_q && (|edge_ev)) // RULE_13
		|=> (summary && !change_irq_o))
		else $error("master enable off stopped flag setting or leaked a request");
	a_wake_request: assert property ((sleep_i && men_q && (|edge_ev)) |=> wake_o) // RULE_08
		else $error("no wake on enabled edge in sleep");
	a_wake_flag_first: assert property ($rose(wake_o) |-> summary) // RULE_09
		else $error("wake raised before flag recorded");
	a_rise_reg_write: assert property (s_rise_reg_write // RULE_10
		|=> (rise_en_q == $past(avm_writedata_i[7:0])))
		else $error("rise enable write not stored");
	a_fall_reg_hold: assert property ( // RULE_11
		!(wr_lane0 && (avm_address_i == pec_pkg::OFF_FALL_EN)) |=> $stable(fall_en_q))
		else $error("fall enable changed without a write");
	a_flags_no_spur: assert property ( // RULE_12
		!(wr_lane0 && (avm_address_i == pec_pkg::OFF_FLAGS))
		|=> ((flags_q & ~$past(flags_q)) == ($past(edge_ev) & ~$past(flags_q))))
		else $error("flag set without an enabled edge");
	a_bus_answer: assert property ( // RULE_12
		(req && avm_waitrequest_o && (state_q == pec_pkg::BUS_IDLE)) |=> !avm_waitrequest_o)
		else $error("waitrequest not released after one cycle");

	// register, status, wake, interrupt and bus checks; a write cycle with an edge must still keep the edge
	sequence s_fall_reg_write;
		wr_lane0 && (avm_address_i == pec_pkg::OFF_FALL_EN);
	endsequence

	sequence s_flag_reg_write;
		wr_lane0 && (avm_address_i == pec_pkg::OFF_FLAGS);
	endsequence

	sequence s_sleep_edge;
		sleep_i && men_q && (|edge_ev);
	endsequence

	a_fall_reg_write: assert property (s_fall_reg_write // RULE_11
		|=> (fall_en_q == $past(avm_writedata_i[7:0])))
		else $error("fall enable write not stored");
	a_rise_reg_hold: assert property ( // RULE_10
		!(wr_lane0 && (avm_address_i == pec_pkg::OFF_RISE_EN)) |=> $stable(rise_en_q))
		else $error("rise enable changed without a write");
	a_flag_write_store: assert property (s_flag_reg_write // RULE_06
		|=> (flags_q == ($past(avm_writedata_i[7:0]) | $past(edge_ev))))
		else $error("flag write not stored with its edges");
	a_wake_clears: assert property (!sleep_i |=> !wake_o) // RULE_08
		else $error("wake still high after the core woke");
	a_wake_cause: assert property ($rose(wake_o) // RULE_08
		|-> ($past(sleep_i) && $past(men_q) && ($past(edge_ev) != 8'h00)))
		else $error("wake raised without an enabled edge in sleep");
	a_wake_status: assert property (s_sleep_edge |=> stat_q[pec_pkg::STAT_WAKE_BIT]) // RULE_08
		else $error("wake event not recorded in status");
	a_edge_status: assert property ((|edge_ev) |=> stat_q[pec_pkg::STAT_CHG_BIT]) // RULE_04
		else $error("edge event not recorded in status");
	a_irq_level: assert property (irq_o == ((stat_q & $past(mask_q)) != 2'h0)) // RULE_04
		else $error("interrupt output disagrees with status and mask");
	a_men_write: assert property ((wr_lane0 && (avm_address_i == pec_pkg::OFF_CTRL)) // RULE_04
		|=> (men_q == $past(avm_writedata_i[pec_pkg::CTRL_MEN_BIT])))
		else $error("master enable write not stored");
	a_mask_write: assert property ( // RULE_04
		(wr_lane0 && (avm_address_i == pec_pkg::OFF_IRQ_MASK))
		|=> (mask_q == $past(avm_writedata_i[1:0])))
		else $error("interrupt mask write not stored");
	a_stat_w1c: assert property ( // RULE_04
		(wr_lane0 && (avm_address_i == pec_pkg::OFF_IRQ_STAT) && !(|edge_ev))
		|=> !(stat_q[pec_pkg::STAT_CHG_BIT] && $past(avm_writedata_i[pec_pkg::STAT_CHG_BIT])))
		else $error("status bit survived its clearing write");
	a_read_zero_hi: assert property ((avm_read_i && (state_q == pec_pkg::BUS_IDLE)) // RULE_12
		|=> (avm_readdata_o[31:8] == 24'h000000))
		else $error("read data above the field not zero");
	a_rdata_hold: assert property ( // RULE_12
		!(avm_read_i && (state_q == pec_pkg::BUS_IDLE)) |=> $stable(avm_readdata_o))
		else $error("read data changed without a read");
	a_wait_idle: assert property (!req |=> avm_waitrequest_o) // RULE_12
		else $error("waitrequest low without a request");

endmodule
`default_nettype wire

//--- tb/pec_pin_model.sv
// partner model: external logic levels on the eight watched pins
// assumes clk_i is the system clock; levels change just after its rising edge
`timescale 1ns/100ps
`default_nettype none
module pec_pin_model (
	input  wire logic       clk_i,
	output logic      [7:0] pins_o
);
	// push-pull driver, so a held level stays valid between changes
	initial pins_o = 8'h00;
	task automatic drive(input logic [7:0] v);
		@(posedge clk_i);
		pins_o <= v;
	endtask
endmodule
`default_nettype wire

//--- tb/test_pin_edge_change_interrupt.sv
// self-checking bench: avalon-mm driver, read scoreboard, pin and sleep scenarios
// assumes pec_top answers each access through waitrequest in its own time
`timescale 1ns/100ps
`default_nettype none
module test_pin_edge_change_interrupt;
	localparam logic [4:0] A_RE = pec_pkg::OFF_RISE_EN;
	localparam logic [4:0] A_FE = pec_pkg::OFF_FALL_EN;
	localparam logic [4:0] A_FL = pec_pkg::OFF_FLAGS;
	localparam logic [4:0] A_CT = pec_pkg::OFF_CTRL;
	localparam logic [4:0] A_ST = pec_pkg::OFF_IRQ_STAT;
	localparam logic [4:0] A_MK = pec_pkg::OFF_IRQ_MASK;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [4:0]  adr = 5'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [3:0]  ben = 4'h1;
	logic        slp = 1'b0;
	logic [31:0] rdat;
	logic        wait_req;
	logic [7:0]  pins;
	logic        chg_irq;
	logic        wake;
	logic        irq;
	logic [31:0] exq[$];
	int          num_errors = 0;
	int          checks_done = 0;
	int          cyc = 0;
	logic [7:0]  re;
	logic [7:0]  fe;
	logic [7:0]  ef;
	pec_pin_model m (.clk_i(clk_i), .pins_o(pins));
	pec_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .avm_address_i(adr), .avm_read_i(rd),
		.avm_write_i(wr), .avm_writedata_i(wdat), .avm_byteenable_i(ben),
		.avm_readdata_o(rdat), .avm_waitrequest_o(wait_req), .watched_pin_i(pins),
		.sleep_i(slp), .change_irq_o(chg_irq), .wake_o(wake), .irq_o(irq));
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			$display("MISMATCH at %0t: run hung", $time);
			tally_and_finish();
		end
	end
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: read %h, expected %h", $time, got, exp);
		end
	endtask
	// outputs are registered, so let two edges land before looking
	task automatic chk_out(input logic [2:0] exp);
		repeat (2) @(negedge clk_i);
		checks_done++;
		if ({chg_irq, wake, irq} !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: outputs %b, expected %b", $time, {chg_irq, wake, irq}, exp);
		end
	endtask
	// read data is taken at the rising edge that sees waitrequest low
	always @(posedge clk_i) begin
		if (rd === 1'b1 && wait_req === 1'b0) cmp_word(rdat, exq.pop_front());
	end
	// holds the request until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_i);
		adr <= a;
		rd <= !w;
		wr <= w;
		wdat <= d;
		do @(posedge clk_i); while (wait_req !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic wrx(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h0, d});
	endtask
	task automatic rdx(input logic [4:0] a, input logic [7:0] e);
		exq.push_back({24'h0, e});
		bus(1'b0, a, 32'h0);
	endtask
	task automatic edge_to(input logic [7:0] v);
		ef |= (re & v & ~pins) | (fe & pins & ~v);
		m.drive(v);
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	// reads the flags, then writes zero, so a flag set after the read is cleared too
	task automatic clr_seen();
		rdx(A_FL, ef);
		wrx(A_FL, ef & (ef ^ 8'hff));
		ef = 8'h00;
	endtask
	initial begin
		void'($urandom(96));
		ef = 8'h00;
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rdx(A_RE, 8'h00);
		rdx(A_FE, 8'h00);
		rdx(A_FL, 8'h00);
		rdx(5'h18, 8'h00);
		re = 8'($urandom);
		wrx(A_RE, re);
		rdx(A_RE, re);
		fe = ~re;
		wrx(A_FE, fe);
		ben <= 4'h0;
		wrx(A_FE, re);
		ben <= 4'h1;
		rdx(A_FE, fe);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			re = i == 2 ? 8'hff : i == 1 ? 8'h00 : 8'($urandom);
			fe = i == 2 ? 8'hff : i == 0 ? 8'h00 : 8'($urandom);
			wrx(A_RE, re);
			wrx(A_FE, fe);
			edge_to(8'($urandom));
			edge_to(8'($urandom));
			edge_to(~pins);
			chk_out(3'b000);
			rdx(A_CT, {6'h0, |ef, 1'b0});
			rdx(A_FL, ef);
			clr_seen();
			rdx(A_FL, 8'h00);
		end
		$display("test edges done");
		re = 8'hff;
		fe = 8'hff;
		wrx(A_RE, re);
		wrx(A_FE, fe);
		wrx(A_CT, 8'h01);
		wrx(A_MK, 8'h01);
		edge_to(pins ^ 8'h01);
		chk_out(3'b101);
		rdx(A_ST, 8'h01);
		wrx(A_MK, 8'h00);
		chk_out(3'b100);
		wrx(A_ST, 8'h01);
		wrx(A_MK, 8'h01);
		chk_out(3'b100);
		clr_seen();
		chk_out(3'b000);
		$display("test interrupt done");
		edge_to(pins ^ 8'h02);
		// pin moves one edge ahead so its event meets the write's commit edge
		m.drive(pins ^ 8'h04);
		wrx(A_FL, 8'h00);
		repeat (4) @(posedge clk_i);
		rdx(A_FL, 8'h04);
		ef = 8'h04;
		clr_seen();
		$display("test clear race done");
		wrx(A_MK, 8'h03);
		slp <= 1'b1;
		edge_to(pins ^ 8'h08);
		chk_out(3'b111);
		@(posedge clk_i) slp <= 1'b0;
		chk_out(3'b101);
		rdx(A_FL, ef);
		rdx(A_ST, 8'h03);
		clr_seen();
		wrx(A_CT, 8'h00);
		wrx(A_MK, 8'h00);
		wrx(A_ST, 8'h03);
		slp <= 1'b1;
		edge_to(pins ^ 8'h10);
		chk_out(3'b000);
		@(posedge clk_i) slp <= 1'b0;
		rdx(A_FL, ef);
		$display("test sleep done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
